//--- src/cpu_operand_addressing.sv
// Programmer register set and operand-address decoder behind an AXI4-Lite slave
// Behaviour
// - Registers live inside the core, never on the memory address space.
// - Two 8-bit accumulators also read and written together as one 16-bit value.
// - Indexed address is base plus 5, 9, 16-bit constant or accumulator.
// - Stack pointer addresses last used slot and serves as base everywhere.
// - Program counter holds next address; base in all but auto update forms.
// - Flags ordered stop-disable, X mask, half, I mask, N, Z, V, C.
// - Half-carry for decimal adjust; N Z V C reflect previous result.
// - Reset sets both masks, stop-disable and fetches the start vector.
// - Words are big endian, high byte at the lower address.
// - Instructions and operands may start at any byte address.
// - Direct mode address is zero high byte plus operand byte.
// - Immediate operand is in the stream, one or two bytes wide.
// - Extended uses a 16-bit address; relative adds 8/16-bit offset to PC.
// - Indexed carries a postbyte then zero, one or two extension bytes.
// - Postbyte bit5 clear gives signed 5-bit offset -16..+15.
// - 111rr0zs: z clear 9-bit offset signed by s, z set 16-bit offset.
// - 111rr011 adds 16-bit offset then uses fetched word as address.
// - rr1pnnnn adjusts base by 1..8 pre or post; PC base is illegal.
// - 111rr1aa adds unsigned first, second or double accumulator.
// - 111rr111 adds double accumulator and uses fetched word as address.
// - One-byte opcodes; prefix 18 hex selects the second opcode page.
`timescale 1ns/1ps
module cpu_operand_addressing
  import operand_addr_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // AXI4-Lite write address and data
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // Programmer registers, inside the core only
  logic [7:0]  firstAccum;
  logic [7:0]  secondAccum;
  logic [15:0] firstIndex;
  logic [15:0] secondIndex;
  logic [15:0] stackPointer;
  logic [15:0] programCounter;
  logic [7:0]  condFlags;
  logic [15:0] resetVector;
  // Decoder inputs and results
  logic [63:0] streamBytes;
  logic [15:0] memWord;
  operand_mode_t  opMode;
  decode_result_t result;
  logic        busy;
  logic        done;
  logic        needVector;
  // Bus channel capture
  logic        awHeld;
  logic        wHeld;
  logic [7:0]  awAddr;
  logic [31:0] wData;
  logic [3:0]  wStrb;
  logic        awBad;

  // Double accumulator, first byte on top
  logic [15:0] doubleAccum;
  assign doubleAccum = {firstAccum, secondAccum};

  // Instruction byte selector
  function automatic logic [7:0] streamByte(input logic [63:0] s, input int idx);
    streamByte = s[idx*8 +: 8];
  endfunction

  // Combinational decode of the buffered instruction
  logic [7:0]  opcByte;
  logic        isPage2;
  logic [3:0]  opcLen;
  logic [7:0]  postByte;
  logic [7:0]  ext1;
  logic [7:0]  ext2;
  logic [15:0] baseReg;
  logic [15:0] nextPc;
  logic [15:0] next_eff;
  logic [3:0]  next_len;
  logic        next_indirect;
  logic        next_illegal;
  logic        next_immed;
  logic        next_baseWrite;
  logic [15:0] next_baseValue;
  index_class_t idxClass;
  logic [1:0]  baseSel;

  always_comb begin
    isPage2 = (streamByte(streamBytes, 0) == PAGE2_PREFIX);
    opcLen  = isPage2 ? 4'd2 : 4'd1;
    opcByte = isPage2 ? streamByte(streamBytes, 1) : streamByte(streamBytes, 0);
    postByte = isPage2 ? streamByte(streamBytes, 2) : streamByte(streamBytes, 1);
    ext1     = isPage2 ? streamByte(streamBytes, 3) : streamByte(streamBytes, 2);
    ext2     = isPage2 ? streamByte(streamBytes, 4) : streamByte(streamBytes, 3);
    // Base field is bits 7:6 in short and auto forms, bits 4:3 in the 111rr forms
    baseSel  = (postByte[7:5] == 3'b111) ? postByte[4:3] : postByte[7:6];
    // Base register select
    unique case (baseSel)
      BASE_FIRST:  baseReg = firstIndex;
      BASE_SECOND: baseReg = secondIndex;
      BASE_STACK:  baseReg = stackPointer;
      BASE_PROG:   baseReg = programCounter;
    endcase
    // Postbyte class
    if (!postByte[5]) begin
      idxClass = indexed_short_mode;
    end else if (postByte[7:5] != 3'b111) begin
      idxClass = indexed_auto_mode;
    end else if (postByte[2:0] == 3'b011) begin
      idxClass = indexed_indirect_mode;
    end else if (postByte[2:0] == 3'b111) begin
      idxClass = accum_indirect_mode;
    end else if (postByte[2]) begin
      idxClass = indexed_accum_mode;
    end else if (postByte[1]) begin
      idxClass = indexed_sixteen_bit_mode;
    end else begin
      idxClass = indexed_nine_bit_mode;
    end
    next_eff       = 16'h0000;
    next_len       = opcLen;
    next_indirect  = 1'b0;
    next_illegal   = 1'b0;
    next_immed     = 1'b0;
    next_baseWrite = 1'b0;
    next_baseValue = baseReg;
    nextPc         = programCounter;
    unique case (opMode)
      inherent_mode: begin
        next_eff = 16'h0000;
      end
      immediate8_mode: begin
        next_immed = 1'b1;
        next_eff   = programCounter + 16'(opcLen);
        next_len   = opcLen + 4'd1;
      end
      immediate16_mode: begin
        next_immed = 1'b1;
        next_eff   = programCounter + 16'(opcLen);
        next_len   = opcLen + 4'd2;
      end
      direct_mode: begin
        next_eff = {8'h00, postByte};
        next_len = opcLen + 4'd1;
      end
      extended_mode: begin
        next_eff = {postByte, ext1};
        next_len = opcLen + 4'd2;
      end
      relative8_mode: begin
        next_len = opcLen + 4'd1;
        nextPc   = programCounter + 16'(next_len);
        next_eff = nextPc + {{8{postByte[7]}}, postByte};
      end
      relative16_mode: begin
        next_len = opcLen + 4'd2;
        nextPc   = programCounter + 16'(next_len);
        next_eff = nextPc + {postByte, ext1};
      end
      indexed_mode: begin
        unique case (idxClass)
          indexed_short_mode: begin
            next_len = opcLen + 4'd1;
            next_eff = baseReg + {{11{postByte[4]}}, postByte[4:0]};
          end
          indexed_auto_mode: begin
            next_len = opcLen + 4'd1;
            // Step 1..8 up, or -8..-1 down when the sign bit is set
            next_baseValue = baseReg + {{12{postByte[3]}}, postByte[3:0]}
                             + {15'h0000, ~postByte[3]};
            next_eff       = postByte[4] ? baseReg : next_baseValue;
            next_illegal   = (postByte[7:6] == BASE_PROG);
            next_baseWrite = !next_illegal;
          end
          indexed_nine_bit_mode: begin
            next_len = opcLen + 4'd2;
            next_eff = baseReg + {{8{postByte[0]}}, ext1};
          end
          indexed_sixteen_bit_mode: begin
            next_len = opcLen + 4'd3;
            next_eff = baseReg + {ext1, ext2};
          end
          indexed_indirect_mode: begin
            next_len      = opcLen + 4'd3;
            next_eff      = baseReg + {ext1, ext2};
            next_indirect = 1'b1;
          end
          indexed_accum_mode: begin
            next_len = opcLen + 4'd1;
            unique case (postByte[1:0])
              2'b00:   next_eff = baseReg + {8'h00, firstAccum};
              2'b01:   next_eff = baseReg + {8'h00, secondAccum};
              default: next_eff = baseReg + doubleAccum;
            endcase
          end
          accum_indirect_mode: begin
            next_len      = opcLen + 4'd1;
            next_eff      = baseReg + doubleAccum;
            next_indirect = 1'b1;
          end
          default: begin
            next_illegal = 1'b1;
          end
        endcase
      end
    endcase
  end

  // Decode sequencer: compute, then resolve indirection through the fetched word
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_CALC    = 2'b01,
    ST_POINTER = 2'b11
  } seq_state_t;
  seq_state_t seqState;
  logic       startPulse;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seqState <= ST_IDLE;
      result   <= '0;
      busy     <= 1'b0;
      done     <= 1'b0;
    end else begin
      unique case (seqState)
        ST_IDLE: begin
          if (startPulse) begin
            seqState <= ST_CALC;
            busy     <= 1'b1;
            done     <= 1'b0;
          end
        end
        ST_CALC: begin
          result.effAddr  <= next_eff;
          result.length   <= next_len;
          result.page2    <= isPage2;
          result.indirect <= next_indirect;
          result.immed    <= next_immed;
          result.illegal  <= next_illegal;
          if (next_indirect) begin
            seqState <= ST_POINTER;
          end else begin
            seqState <= ST_IDLE;
            busy     <= 1'b0;
            done     <= 1'b1;
          end
        end
        ST_POINTER: begin
          result.effAddr <= memWord;
          seqState       <= ST_IDLE;
          busy           <= 1'b0;
          done           <= 1'b1;
        end
        default: begin
          seqState <= ST_IDLE;
        end
      endcase
    end
  end

  // Bus write channel capture; address and data accepted in either order
  logic doWrite;
  assign doWrite = awHeld && wHeld && !s_axi_bvalid;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld        <= 1'b0;
      wHeld         <= 1'b0;
      awAddr        <= 8'h00;
      awBad         <= 1'b0;
      wData         <= 32'h0000_0000;
      wStrb         <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end else begin
      s_axi_awready <= !awHeld && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !wHeld && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr[ADDR_W-1:0];
        // Full address judged at capture, the master may move it afterwards
        awBad  <= (s_axi_awaddr[ADDR_W-1:0] > OFS_RESET_VEC) || (s_axi_awaddr[31:ADDR_W] != '0)
                  || (s_axi_awaddr[1:0] != 2'b00);
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld       <= 1'b0;
        wHeld        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= awBad ? 2'b10 : 2'b00;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register writes; start of a decode comes from the control word
  assign startPulse = doWrite && !awBad && awAddr == OFS_DECODE_CTRL && wStrb[0] && wData[0]
                      && !busy;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      firstAccum     <= 8'h00;
      secondAccum    <= 8'h00;
      firstIndex     <= 16'h0000;
      secondIndex    <= 16'h0000;
      stackPointer   <= 16'h0000;
      programCounter <= 16'h0000;
      condFlags      <= COND_FLAGS_RESET;
      streamBytes    <= 64'h0000_0000_0000_0000;
      memWord        <= 16'h0000;
      opMode         <= inherent_mode;
      resetVector    <= 16'h0000;
      needVector     <= 1'b1;
    end else begin
      if (needVector) begin
        programCounter <= resetVector;
        needVector     <= 1'b0;
      end
      if (seqState == ST_CALC && next_baseWrite) begin
        unique case (postByte[7:6])
          BASE_FIRST:  firstIndex   <= next_baseValue;
          BASE_SECOND: secondIndex  <= next_baseValue;
          default:     stackPointer <= next_baseValue;
        endcase
      end
      if (doWrite && !awBad) begin
        unique case (awAddr)
          OFS_ACCUM_PAIR: begin
            if (wStrb[1]) firstAccum  <= wData[15:8];
            if (wStrb[0]) secondAccum <= wData[7:0];
          end
          OFS_FIRST_INDEX:  firstIndex     <= wData[15:0];
          OFS_SECOND_INDEX: secondIndex    <= wData[15:0];
          OFS_STACK_PTR:    stackPointer   <= wData[15:0];
          OFS_PROG_CNT:     programCounter <= wData[15:0];
          OFS_COND_FLAGS:   condFlags      <= wData[7:0];
          OFS_DECODE_CTRL:  opMode         <= operand_mode_t'(wData[10:8]);
          OFS_STREAM_LO:    streamBytes[31:0]  <= wData;
          OFS_STREAM_HI:    streamBytes[63:32] <= wData;
          OFS_MEM_WORD:     memWord        <= wData[15:0];
          OFS_RESET_VEC:    resetVector    <= wData[15:0];
          default: begin
          end
        endcase
      end
    end
  end

  // Read channel: one read at a time, answered two edges after the address
  logic [31:0] readWord;
  logic        arBad;
  assign arBad = (s_axi_araddr[ADDR_W-1:0] > OFS_RESET_VEC) || (s_axi_araddr[31:ADDR_W] != '0)
                 || (s_axi_araddr[1:0] != 2'b00);
  always_comb begin
    unique case (s_axi_araddr[ADDR_W-1:0])
      OFS_ACCUM_PAIR:   readWord = {16'h0000, doubleAccum};
      OFS_FIRST_INDEX:  readWord = {16'h0000, firstIndex};
      OFS_SECOND_INDEX: readWord = {16'h0000, secondIndex};
      OFS_STACK_PTR:    readWord = {16'h0000, stackPointer};
      OFS_PROG_CNT:     readWord = {16'h0000, programCounter};
      OFS_COND_FLAGS:   readWord = {24'h00_0000, condFlags};
      OFS_DECODE_CTRL:  readWord = {21'h00_0000, opMode, 8'h00};
      OFS_STREAM_LO:    readWord = streamBytes[31:0];
      OFS_STREAM_HI:    readWord = streamBytes[63:32];
      OFS_MEM_WORD:     readWord = {16'h0000, memWord};
      OFS_RESULT:       readWord = {16'h0000, result.effAddr};
      OFS_STATUS:       readWord = {8'h00, opcByte, 4'h0, result.length, 2'b00,
                                    result.immed, result.indirect, result.page2,
                                    result.illegal, done, busy};
      OFS_RESET_VEC:    readWord = {16'h0000, resetVector};
      default:          readWord = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= arBad ? 32'h0000_0000 : readWord;
        s_axi_rresp  <= arBad ? 2'b10 : 2'b00;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Checks
  property p_reset_flags;
    @(posedge clk) disable iff (!rst_n)
    $rose(rst_n) |-> condFlags[CF_STOPDIS] && condFlags[CF_XMASK] && condFlags[CF_IMASK];
  endproperty
  a_reset_flags: assert property (p_reset_flags) else $error("masks not set after reset");

  property p_direct_page;
    @(posedge clk) disable iff (!rst_n)
    (seqState == ST_CALC && opMode == direct_mode) |=> result.effAddr[15:8] == 8'h00;
  endproperty
  a_direct_page: assert property (p_direct_page) else $error("direct address off page");

  property p_short_offset;
    @(posedge clk) disable iff (!rst_n)
    (seqState == ST_CALC && opMode == indexed_mode && !postByte[5])
      |-> next_eff == baseReg + {{11{postByte[4]}}, postByte[4:0]};
  endproperty
  a_short_offset: assert property (p_short_offset) else $error("short offset wrong");

  property p_pc_auto_illegal;
    @(posedge clk) disable iff (!rst_n)
    (seqState == ST_CALC && opMode == indexed_mode && idxClass == indexed_auto_mode)
      |=> $stable(programCounter);
  endproperty
  a_pc_auto_illegal: assert property (p_pc_auto_illegal) else $error("pc auto accepted");

  property p_indirect_fetch;
    @(posedge clk) disable iff (!rst_n)
    (seqState == ST_CALC && next_indirect) |=> seqState == ST_POINTER ##1 done;
  endproperty
  a_indirect_fetch: assert property (p_indirect_fetch) else $error("no pointer step");

  property p_accum_d;
    @(posedge clk) disable iff (!rst_n)
    (seqState == ST_CALC && opMode == indexed_mode && idxClass == indexed_accum_mode
     && postByte[1:0] == 2'b10) |-> next_eff == baseReg + doubleAccum;
  endproperty
  a_accum_d: assert property (p_accum_d) else $error("accumulator offset wrong");

  property p_page2;
    @(posedge clk) disable iff (!rst_n)
    (seqState == ST_CALC && streamByte(streamBytes, 0) == PAGE2_PREFIX) |=> result.page2;
  endproperty
  a_page2: assert property (p_page2) else $error("page two missed");

  property p_done_bound;
    @(posedge clk) disable iff (!rst_n)
    startPulse |=> ##[1:2] done;
  endproperty
  a_done_bound: assert property (p_done_bound) else $error("decode too slow");

endmodule // cpu_operand_addressing

//--- src/operand_addr_pkg.sv
// Package: register map, postbyte fields, modes and constants of the operand-address unit
package operand_addr_pkg;

  // AXI4-Lite register byte offsets
  localparam logic [7:0] OFS_ACCUM_PAIR   = 8'h00; // first (15:8) and second (7:0) accumulators
  localparam logic [7:0] OFS_FIRST_INDEX  = 8'h04;
  localparam logic [7:0] OFS_SECOND_INDEX = 8'h08;
  localparam logic [7:0] OFS_STACK_PTR    = 8'h0C;
  localparam logic [7:0] OFS_PROG_CNT     = 8'h10;
  localparam logic [7:0] OFS_COND_FLAGS   = 8'h14;
  localparam logic [7:0] OFS_DECODE_CTRL  = 8'h18; // write: bit0 start, 10:8 operand mode
  localparam logic [7:0] OFS_STREAM_LO    = 8'h1C; // instruction bytes 0..3, byte 0 at 7:0
  localparam logic [7:0] OFS_STREAM_HI    = 8'h20; // instruction bytes 4..7
  localparam logic [7:0] OFS_MEM_WORD     = 8'h24; // pointer word fetched for indirect modes
  localparam logic [7:0] OFS_RESULT       = 8'h28; // 15:0 effective address
  localparam logic [7:0] OFS_STATUS       = 8'h2C; // see status bits below
  localparam logic [7:0] OFS_RESET_VEC    = 8'h30; // start vector
  localparam int         ADDR_W           = 8;

  // Status bit positions
  localparam int ST_BUSY     = 0;
  localparam int ST_DONE     = 1;
  localparam int ST_ILLEGAL  = 2;
  localparam int ST_PAGE2    = 3;
  localparam int ST_INDIRECT = 4;
  localparam int ST_IMMED    = 5;
  localparam int ST_LEN_LO   = 8;  // instruction length, 4 bits
  localparam int ST_OPC_LO   = 16; // opcode byte

  // Condition flag positions, most significant first
  localparam int CF_STOPDIS = 7;
  localparam int CF_XMASK   = 6;
  localparam int CF_HALF    = 5;
  localparam int CF_IMASK   = 4;
  localparam int CF_NEG     = 3;
  localparam int CF_ZERO    = 2;
  localparam int CF_OVF     = 1;
  localparam int CF_CARRY   = 0;
  localparam logic [7:0] COND_FLAGS_RESET = 8'hD0; // stop-disable, both masks
  localparam logic [7:0] PAGE2_PREFIX     = 8'h18;
  localparam logic [15:0] RESET_VECTOR_ADDR = 16'hFFFE;

  // Base select field codes
  localparam logic [1:0] BASE_FIRST  = 2'b00;
  localparam logic [1:0] BASE_SECOND = 2'b01;
  localparam logic [1:0] BASE_STACK  = 2'b10;
  localparam logic [1:0] BASE_PROG   = 2'b11;

  // Operand mode requested by the opcode decoder
  typedef enum logic [2:0] {
    inherent_mode   = 3'd0,
    immediate8_mode = 3'd1,
    immediate16_mode= 3'd2,
    direct_mode     = 3'd3,
    extended_mode   = 3'd4,
    relative8_mode  = 3'd5,
    relative16_mode = 3'd6,
    indexed_mode    = 3'd7
  } operand_mode_t;

  // Indexed postbyte class
  typedef enum logic [2:0] {
    indexed_short_mode       = 3'd0,
    indexed_auto_mode        = 3'd1,
    indexed_nine_bit_mode    = 3'd2,
    indexed_sixteen_bit_mode = 3'd3,
    indexed_indirect_mode    = 3'd4,
    indexed_accum_mode       = 3'd5,
    accum_indirect_mode      = 3'd6
  } index_class_t;

  // Result of one decode
  typedef struct packed {
    logic [15:0] effAddr;
    logic [3:0]  length;
    logic        page2;
    logic        indirect;
    logic        immed;
    logic        illegal;
  } decode_result_t;

endpackage

//--- testbench/pointer_memory.sv
// Byte-wide memory model that hands out big-endian pointer words
`timescale 1ns/1ps
module pointer_memory (
  // Lookup
  input  wire logic [15:0] addr,
  output logic      [15:0] word
);
  logic [7:0] mem [0:15];
  // Distinct byte pattern so a swapped word is caught
  initial for (int i = 0; i < 16; i++) mem[i] = 8'hA0 + 8'(i);
  // High byte at the lower address, any start address allowed
  assign word = {mem[addr[3:0]], mem[addr[3:0] + 4'h1]};
endmodule // pointer_memory

//--- testbench/test_cpu_operand_addressing.sv
// Self-checking bench for the operand-address unit over AXI4-Lite
`timescale 1ns/1ps
module test_cpu_operand_addressing;
  import operand_addr_pkg::*;
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
  $display("ERROR %0t value mismatch", $time); end end
  logic        clk = 0, rst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  logic        s_axi_bready = 1, s_axi_rready = 1, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [15:0] memAddr = 0, memWord, ea;
  logic [31:0] d, st;
  int          failures = 0, n_tests = 0;
  cpu_operand_addressing DUT (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  pointer_memory mem (.addr(memAddr), .word(memWord));
  // Clock
  always #5 clk = ~clk;
  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    s_axi_awaddr <= {24'h00_0000, a};
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    rs = s_axi_bresp;
  endtask
  // Read: address held until taken, data captured with rvalid
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    s_axi_araddr <= {24'h00_0000, a};
    s_axi_arvalid <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    v = s_axi_rdata;
    rs = s_axi_rresp;
  endtask
  // One decode: load stream, start, wait for done, fetch result
  task automatic dec(input logic [2:0] m, input logic [31:0] lo);
    wr(OFS_STREAM_LO, lo, r);
    wr(OFS_DECODE_CTRL, {21'h00_0000, m, 8'h01}, r);
    forever begin
      rd(OFS_STATUS, st, r);
      if (st[ST_DONE] === 1'b1) break;
    end
    rd(OFS_RESULT, d, r);
    ea = d[15:0];
  endtask
  task automatic t_reset();
    rd(OFS_COND_FLAGS, d, r); `CHK(d[7:0], 8'hD0)
    rd(OFS_PROG_CNT, d, r); `CHK(d[15:0], 16'h0000)
    $display("reset test done");
  endtask
  task automatic t_accum();
    wr(OFS_ACCUM_PAIR, 32'h0000_1234, r); rd(OFS_ACCUM_PAIR, d, r); `CHK(d[15:0], 16'h1234)
    wr(OFS_FIRST_INDEX, 32'h0000_1000, r);
    dec(indexed_mode, 32'h0000_E4A6); `CHK(ea, 16'h1012)
    dec(indexed_mode, 32'h0000_E5A6); `CHK(ea, 16'h1034)
    dec(indexed_mode, 32'h0000_E6A6); `CHK(ea, 16'h2234)
    $display("accumulator test done");
  endtask
  task automatic t_index();
    wr(OFS_SECOND_INDEX, 32'h0000_0005, r); wr(OFS_STACK_PTR, 32'h0000_2000, r);
    dec(indexed_mode, 32'h0000_50A6); `CHK(ea, 16'hFFF5)
    dec(indexed_mode, 32'h0000_8FA6); `CHK(ea, 16'h200F)
    dec(indexed_mode, 32'h0000_E1A6); `CHK(ea, 16'h0F00)
    dec(indexed_mode, 32'h0180_E2A6); `CHK(ea, 16'h9001)
    `CHK(st[11:8], 4'h4)
    $display("indexed offset test done");
  endtask
  task automatic t_auto();
    dec(indexed_mode, 32'h0000_37A6); `CHK(ea, 16'h1000)
    rd(OFS_FIRST_INDEX, d, r); `CHK(d[15:0], 16'h1008)
    dec(indexed_mode, 32'h0000_AFA6); `CHK(ea, 16'h1FFF)
    rd(OFS_STACK_PTR, d, r); `CHK(d[15:0], 16'h1FFF)
    $display("auto update test done");
  endtask
  task automatic t_indirect();
    memAddr <= 16'h0003;
    @(posedge clk);
    wr(OFS_MEM_WORD, {16'h0000, memWord}, r);
    dec(indexed_mode, 32'h0000_E3A6); `CHK(ea, 16'hA3A4)
    `CHK(st[ST_INDIRECT], 1'b1)
    dec(indexed_mode, 32'h0000_E7A6); `CHK(ea, 16'hA3A4)
    $display("indirect test done");
  endtask
  task automatic t_modes();
    wr(OFS_PROG_CNT, 32'h0000_0100, r);
    dec(direct_mode, 32'h0000_A596); `CHK(ea, 16'h00A5)
    dec(extended_mode, 32'h0034_12B6); `CHK(ea, 16'h1234)
    dec(immediate8_mode, 32'h0000_5586); `CHK(ea, 16'h0101)
    dec(relative8_mode, 32'h0000_FE20); `CHK(ea, 16'h0100)
    dec(extended_mode, 32'h3412_B618); `CHK(st[ST_PAGE2], 1'b1)
    `CHK(ea, 16'h1234)
    $display("mode test done");
  endtask
  task automatic t_unmapped();
    wr(8'h3C, 32'h0000_FFFF, r); `CHK(r, 2'b10)
    rd(8'h3C, d, r); `CHK(r, 2'b10)
    `CHK(d, 32'h0000_0000)
    $display("unmapped test done");
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset(); t_accum(); t_index(); t_auto(); t_indirect(); t_modes(); t_unmapped();
    give_verdict();
  end
  // Watchdog
  initial begin
    #200000;
    failures++;
    give_verdict();
  end
endmodule // test_cpu_operand_addressing
